/* abc_pkg.sv */
/*
  Shared constants and types for the address break comparator: register
  offsets, field positions, reset values and the bus access codes.
  Assumes a 32-bit AHB-Lite register bus and a 16-bit CPU bus monitor port.
*/
package abc_pkg;

  // Register byte offsets on the AHB-Lite bus
  localparam logic [7:0] ABC_OFS_STATUS = 8'h00;
  localparam logic [7:0] ABC_OFS_ADDR = 8'h04;
  localparam logic [7:0] ABC_OFS_CTRL = 8'h08;
  localparam logic [7:0] ABC_OFS_DATA = 8'h0c;
  localparam logic [7:0] ABC_OFS_EVSTAT = 8'h10;
  localparam logic [7:0] ABC_OFS_EVMASK = 8'h14;

  // Status and enable register fields
  localparam int ABC_FLAG_BIT = 7;
  localparam int ABC_IEN_BIT = 6;
  localparam logic [5:0] ABC_STATUS_RSVD = 6'h3f;
  localparam logic ABC_IEN_RESET = 1'b0;

  // Match address and match data
  localparam logic [15:0] ABC_ADDR_RESET = 16'hffff;
  localparam logic [7:0] ABC_DATA_RESET = 8'h00;

  // Break condition control fields
  localparam int ABC_CTRL_EN_BIT = 0;
  localparam int ABC_CTRL_SEL_LSB = 1;
  localparam int ABC_CTRL_DEN_BIT = 3;
  localparam logic [3:0] ABC_CTRL_RESET = 4'h0;

  // Interrupt event bits
  localparam int ABC_EV_HIT = 0;
  localparam int ABC_EV_NOLANE = 1;
  localparam logic [1:0] ABC_EV_RESET = 2'h0;

  // AHB-Lite codes
  localparam logic [2:0] ABC_HSIZE_WORD = 3'h2;
  localparam logic [1:0] ABC_HRESP_OKAY = 2'h0;

  // CPU cycle kinds
  typedef enum logic [1:0] {
    ABC_KIND_FETCH = 2'h0,
    ABC_KIND_READ = 2'h1,
    ABC_KIND_WRITE = 2'h2
  } abc_kind_t;

  // Address spaces, with their data path width
  typedef enum logic [1:0] {
    ABC_SPACE_ROM = 2'h0,
    ABC_SPACE_RAM = 2'h1,
    ABC_SPACE_IO8 = 2'h2,
    ABC_SPACE_IO16 = 2'h3
  } abc_space_t;

  // Which cycles may break
  typedef enum logic [1:0] {
    ABC_SEL_FETCH = 2'h0,
    ABC_SEL_READ = 2'h1,
    ABC_SEL_WRITE = 2'h2,
    ABC_SEL_DATA = 2'h3
  } abc_sel_t;

  // Word split for 8-bit I/O, Gray coded
  typedef enum logic {
    ABC_SPLIT_IDLE = 1'b0,
    ABC_SPLIT_SECOND = 1'b1
  } abc_split_t;

endpackage : abc_pkg

/* abc_lane_select.sv */
/*
  Byte lane selector: picks the data byte compared by the break unit from
  the access size, the address parity and the address space.
  Assumes the upper lane is data[15:8]; purely combinational.
*/
`timescale 1ns/1ns
module abc_lane_select
  import abc_pkg::*;
(
  input logic [1:0] space,
  input logic word,
  input logic addr_odd,
  input logic [15:0] data,
  output logic [7:0] lane_byte,
  output logic lane_ok
);

  logic use_lower;

  // Lane choice per space and access shape
  always_comb
  begin
    use_lower = 1'b0;
    lane_ok = 1'b1;
    unique case (abc_space_t'(space))
      ABC_SPACE_ROM, ABC_SPACE_RAM: use_lower = word & addr_odd;
      ABC_SPACE_IO8: use_lower = 1'b0;
      ABC_SPACE_IO16:
      begin
        use_lower = word & addr_odd;
        lane_ok = word;
      end
    endcase
    lane_byte = use_lower ? data[7:0] : data[15:8];
  end

endmodule : abc_lane_select

/* abc_hit_flag.sv */
/*
  Break hit flag with read-then-write-zero clearing.
  Assumes single-cycle read and write strobes from the register slave,
  all on mclk.
*/
`timescale 1ns/1ns
module abc_hit_flag
  import abc_pkg::*;
(
  input logic mclk,
  input logic resetn,
  input logic hit,
  input logic rd_strobe,
  input logic wr_strobe,
  input logic wr_flag_val,
  output logic flag_q
);

  logic armed_q;
  logic clear_req;

  // zero write clears only after a read of one
  assign clear_req = wr_strobe & ~wr_flag_val & armed_q;

  // Arming remembers a read that returned one
  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
      armed_q <= 1'b0;
    else if (wr_strobe || !flag_q)
      armed_q <= 1'b0;
    else if (rd_strobe)
      armed_q <= 1'b1;
  end

  // set on hit, set beats clear
  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
      flag_q <= 1'b0;
    else if (hit)
      flag_q <= 1'b1;
    else if (clear_req)
      flag_q <= 1'b0;
  end

endmodule : abc_hit_flag

/* abc_top.sv */
/*
  Address break comparator: watches the CPU bus for a programmed address,
  optionally with a data byte, and flags and interrupts on a match.
  Assumes the CPU monitor port and the AHB-Lite slave share mclk, so no
  input synchroniser is needed; one slave drives hreadyout as hready.
*/
// What this block does
// - Word access to 8-bit I/O is seen as two byte accesses.
// - Memory word uses upper lane even, lower odd; bytes use upper.
// - 8-bit I/O registers always compare the upper byte lane.
// - 16-bit I/O words pick lane by parity; byte lane undefined.
// - Flag bit 7 sets when the programmed break condition matches.
// - Flag clears only by writing zero after reading it as one.
// - Bit 6 enables the break interrupt, reset to zero.
// - Status bits 5 to 0 read as ones, writes ignored.
// - Sixteen-bit match address, high and low bytes, resets to all ones.
`timescale 1ns/1ns
module abc_top
  import abc_pkg::*;
(
  input logic mclk,
  input logic resetn,
  // AHB-Lite slave
  input logic hsel,
  input logic [31:0] haddr,
  input logic [1:0] htrans,
  input logic hwrite,
  input logic [2:0] hsize,
  input logic [31:0] hwdata,
  input logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic [1:0] hresp,
  // CPU bus monitor
  input logic cpu_valid,
  input logic [1:0] cpu_kind,
  input logic [1:0] cpu_space,
  input logic cpu_word,
  input logic [15:0] cpu_addr,
  input logic [15:0] cpu_data,
  output logic cpu_ready,
  // Results
  output logic break_flag,
  output logic break_irq,
  output logic irq
);

  // Bus slave state
  logic dph_valid_q;
  logic dph_write_q;
  logic [7:0] dph_addr_q;
  logic rd_done_q;
  logic [31:0] hrdata_q;
  logic accept;
  logic read_phase;
  logic rd_load;
  logic wr_fire;
  logic [31:0] rd_value;

  // Registers
  logic ien_q;
  logic [15:0] match_addr_q;
  logic [3:0] ctrl_q;
  logic [7:0] match_data_q;
  logic [1:0] ev_stat_q;
  logic [1:0] ev_mask_q;

  // Split and observation
  abc_split_t split_q;
  logic [15:0] split_addr_q;
  logic [1:0] split_kind_q;
  logic [7:0] split_byte_q;
  logic obs_valid;
  logic [1:0] obs_kind;
  logic [1:0] obs_space;
  logic obs_word;
  logic [15:0] obs_addr;
  logic [15:0] obs_data;
  logic [7:0] lane_byte;
  logic lane_ok;

  // Match terms
  logic ctrl_en;
  logic ctrl_den;
  abc_sel_t ctrl_sel;
  logic kind_ok;
  logic addr_ok;
  logic data_cycle;
  logic data_ok;
  logic hit;
  logic nolane;
  logic [1:0] ev_set;

  // Address phase taken when selected and bus ready
  assign accept = hsel & htrans[1] & hready;
  assign read_phase = dph_valid_q & ~dph_write_q;
  assign rd_load = read_phase & ~rd_done_q;
  assign wr_fire = dph_valid_q & dph_write_q;

  // Reads wait one cycle so the data comes from a flop
  assign hreadyout = ~rd_load;
  assign hrdata = hrdata_q;
  assign hresp = ABC_HRESP_OKAY;

  // Data phase tracking
  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      dph_valid_q <= 1'b0;
      dph_write_q <= 1'b0;
      dph_addr_q <= 8'h00;
    end
    else if (accept)
    begin
      dph_valid_q <= 1'b1;
      dph_write_q <= hwrite;
      dph_addr_q <= {haddr[7:2], 2'b00};
    end
    else if (hready)
      dph_valid_q <= 1'b0;
  end

  // Read wait state and read data capture
  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      rd_done_q <= 1'b0;
      hrdata_q <= 32'h0000_0000;
    end
    else
    begin
      rd_done_q <= rd_load;
      if (rd_load)
        hrdata_q <= rd_value;
    end
  end

  // Read multiplexer; unmapped offsets read zero
  always_comb
  begin
    rd_value = 32'h0000_0000;
    unique case (dph_addr_q)
      ABC_OFS_STATUS: rd_value[7:0] = {break_flag, ien_q, ABC_STATUS_RSVD};
      ABC_OFS_ADDR: rd_value[15:0] = match_addr_q;
      ABC_OFS_CTRL: rd_value[3:0] = ctrl_q;
      ABC_OFS_DATA: rd_value[7:0] = match_data_q;
      ABC_OFS_EVSTAT: rd_value[1:0] = ev_stat_q;
      ABC_OFS_EVMASK: rd_value[1:0] = ev_mask_q;
      default: rd_value = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
      ien_q <= ABC_IEN_RESET;
    else if (wr_fire && dph_addr_q == ABC_OFS_STATUS)
      ien_q <= hwdata[ABC_IEN_BIT];
  end

  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
      match_addr_q <= ABC_ADDR_RESET;
    else if (wr_fire && dph_addr_q == ABC_OFS_ADDR)
      match_addr_q <= hwdata[15:0];
  end

  // Condition control and match data
  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      ctrl_q <= ABC_CTRL_RESET;
      match_data_q <= ABC_DATA_RESET;
    end
    else if (wr_fire)
    begin
      if (dph_addr_q == ABC_OFS_CTRL)
        ctrl_q <= hwdata[3:0];
      if (dph_addr_q == ABC_OFS_DATA)
        match_data_q <= hwdata[7:0];
    end
  end

  // Interrupt mask
  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
      ev_mask_q <= ABC_EV_RESET;
    else if (wr_fire && dph_addr_q == ABC_OFS_EVMASK)
      ev_mask_q <= hwdata[1:0];
  end

  // Sticky events, write one to clear, set wins
  assign ev_set = {nolane, hit};

  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
      ev_stat_q <= ABC_EV_RESET;
    else if (wr_fire && dph_addr_q == ABC_OFS_EVSTAT)
      ev_stat_q <= (ev_stat_q & ~hwdata[1:0]) | ev_set;
    else
      ev_stat_q <= ev_stat_q | ev_set;
  end

  // split word access to 8-bit I/O
  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      split_q <= ABC_SPLIT_IDLE;
      split_addr_q <= 16'h0000;
      split_kind_q <= 2'h0;
      split_byte_q <= 8'h00;
    end
    else
    begin
      unique case (split_q)
        ABC_SPLIT_IDLE:
        begin
          if (cpu_valid && cpu_word && abc_space_t'(cpu_space) == ABC_SPACE_IO8)
          begin
            split_q <= ABC_SPLIT_SECOND;
            split_addr_q <= cpu_addr | 16'h0001;
            split_kind_q <= cpu_kind;
            split_byte_q <= cpu_data[7:0];
          end
        end
        ABC_SPLIT_SECOND: split_q <= ABC_SPLIT_IDLE;
      endcase
    end
  end

  // Stall the CPU monitor during the second byte
  assign cpu_ready = (split_q == ABC_SPLIT_IDLE);

  always_comb
  begin
    if (split_q == ABC_SPLIT_SECOND)
    begin
      obs_valid = 1'b1;
      obs_kind = split_kind_q;
      obs_space = ABC_SPACE_IO8;
      obs_word = 1'b0;
      obs_addr = split_addr_q;
      obs_data = {split_byte_q, 8'h00};
    end
    else
    begin
      obs_valid = cpu_valid;
      obs_kind = cpu_kind;
      obs_space = cpu_space;
      obs_word = cpu_word & (abc_space_t'(cpu_space) != ABC_SPACE_IO8);
      obs_addr = cpu_addr;
      obs_data = cpu_data;
    end
  end

  abc_lane_select u_lane (
    .space(obs_space),
    .word(obs_word),
    .addr_odd(obs_addr[0]),
    .data(obs_data),
    .lane_byte(lane_byte),
    .lane_ok(lane_ok)
  );

  // Control fields
  assign ctrl_en = ctrl_q[ABC_CTRL_EN_BIT];
  assign ctrl_den = ctrl_q[ABC_CTRL_DEN_BIT];
  assign ctrl_sel = abc_sel_t'(ctrl_q[ABC_CTRL_SEL_LSB +: 2]);

  // Cycle kind filter
  always_comb
  begin
    kind_ok = 1'b0;
    unique case (ctrl_sel)
      ABC_SEL_FETCH: kind_ok = (obs_kind == ABC_KIND_FETCH);
      ABC_SEL_READ: kind_ok = (obs_kind == ABC_KIND_READ);
      ABC_SEL_WRITE: kind_ok = (obs_kind == ABC_KIND_WRITE);
      ABC_SEL_DATA: kind_ok = (obs_kind == ABC_KIND_READ) || (obs_kind == ABC_KIND_WRITE);
    endcase
  end

  // exact address compare, fetch uses first byte
  assign addr_ok = (obs_addr == match_addr_q);
  assign data_cycle = (obs_kind != ABC_KIND_FETCH);

  // data byte compare on the chosen lane
  assign data_ok = ~(ctrl_den & data_cycle) | (lane_ok & (lane_byte == match_data_q));

  assign hit = ctrl_en & obs_valid & kind_ok & addr_ok & data_ok;

  // with data compare on, undefined lane reported, never a hit
  assign nolane = ctrl_en & ctrl_den & obs_valid & kind_ok & addr_ok & data_cycle & ~lane_ok;

  abc_hit_flag u_flag (
    .mclk(mclk),
    .resetn(resetn),
    .hit(hit),
    .rd_strobe(rd_load && dph_addr_q == ABC_OFS_STATUS),
    .wr_strobe(wr_fire && dph_addr_q == ABC_OFS_STATUS),
    .wr_flag_val(hwdata[ABC_FLAG_BIT]),
    .flag_q(break_flag)
  );

  assign break_irq = break_flag & ien_q;

  // Summary interrupt from unmasked events
  assign irq = |(ev_stat_q & ev_mask_q);

endmodule : abc_top

/* abc_checker.sv */
/*
  Port checker for the break unit: bus timing, flag and interrupt links.
  Bound onto the top module; one clock, asynchronous low reset.
*/
`timescale 1ns/1ns
module abc_checker
  import abc_pkg::*;
(
  input logic mclk,
  input logic resetn,
  input logic hsel,
  input logic [1:0] htrans,
  input logic hwrite,
  input logic hready,
  input logic hreadyout,
  input logic [1:0] hresp,
  input logic cpu_valid,
  input logic cpu_word,
  input logic [1:0] cpu_space,
  input logic cpu_ready,
  input logic break_flag,
  input logic break_irq
);
  logic wr_q;
  default clocking @(posedge mclk); endclocking
  default disable iff (!resetn);
  // Marks a register write data phase
  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
      wr_q <= 1'b0;
    else
      wr_q <= hsel && htrans[1] && hready && hwrite;
  end
  AST_IRQ_NEEDS_FLAG:
    assert property (break_irq |-> break_flag) else $error("irq without flag");
  AST_FLAG_FALL:
    assert property ($fell(break_flag) |-> $past(wr_q)) else $error("flag fell without write");
  AST_IRQ_RISE:
    assert property ($rose(break_irq) |-> $rose(break_flag) || $past(wr_q))
      else $error("irq rose without cause");
  AST_IRQ_FALL:
    assert property ($fell(break_irq) |-> $past(wr_q)) else $error("irq fell without write");
  AST_FLAG_RISE:
    assert property ($rose(break_flag) |-> $past(cpu_valid) || !$past(cpu_ready))
      else $error("flag rose without cpu cycle");
  AST_SECOND_BYTE:
    assert property (cpu_valid && cpu_ready && cpu_word && cpu_space == ABC_SPACE_IO8
      |=> !cpu_ready ##1 cpu_ready) else $error("no second byte stall");
  AST_READ_WAIT:
    assert property (hsel && htrans[1] && hready && !hwrite |=> !hreadyout ##1 hreadyout)
      else $error("read wait state wrong");
  AST_RESP_OKAY:
    assert property (hresp == ABC_HRESP_OKAY) else $error("response not okay");
  // Main scenarios
  cover property ($rose(break_flag));
  cover property ($rose(break_irq));
  cover property ($fell(cpu_ready));
endmodule : abc_checker

/* abc_cpu_model.sv */
/*
  CPU bus master model issuing single monitored bus cycles.
  Assumes the bench calls go at a rising edge of mclk.
*/
`timescale 1ns/1ns
module abc_cpu_model
(
  input logic mclk,
  input logic cpu_ready,
  output logic cpu_valid,
  output logic [1:0] cpu_kind,
  output logic [1:0] cpu_space,
  output logic cpu_word,
  output logic [15:0] cpu_addr,
  output logic [15:0] cpu_data
);
  // Idle bus at time zero
  initial
  begin
    cpu_valid = 1'b0;
    {cpu_kind, cpu_space, cpu_word, cpu_addr, cpu_data} = '0;
  end
  // One cycle access, then release with scrambled lines
  task automatic go(input logic [1:0] k, input logic [1:0] s, input logic w,
                    input logic [15:0] a, input logic [15:0] d);
    @(negedge mclk);
    while (cpu_ready !== 1'b1)
      @(negedge mclk);
    @(posedge mclk);
    cpu_valid <= 1'b1;
    {cpu_kind, cpu_space, cpu_word, cpu_addr, cpu_data} <= {k, s, w, a, d};
    @(posedge mclk);
    cpu_valid <= 1'b0;
    cpu_addr <= ~a;
    cpu_data <= ~d;
  endtask : go
endmodule : abc_cpu_model

/* abc_tb.sv */
/*
  Self-checking bench: AHB-Lite register tasks and a lane table run
  through the CPU model. Assumes a single mclk domain.
*/
`timescale 1ns/1ns
module testbench
  import abc_pkg::*;
;
  logic mclk = 1'b0;
  logic resetn = 1'b0;
  logic hsel = 1'b1;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic hreadyout, cpu_ready, cpu_valid, cpu_word, break_flag, break_irq, irq;
  logic [31:0] hrdata;
  logic [1:0] hresp, cpu_kind, cpu_space;
  logic [15:0] cpu_addr, cpu_data;
  logic [57:0] tbl [10];
  int num_errors = 0;
  int tests_run = 0;
  int cycles = 0;
  abc_top uut (.mclk(mclk), .resetn(resetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(ABC_HSIZE_WORD), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .cpu_valid(cpu_valid),
    .cpu_kind(cpu_kind), .cpu_space(cpu_space), .cpu_word(cpu_word), .cpu_addr(cpu_addr),
    .cpu_data(cpu_data), .cpu_ready(cpu_ready), .break_flag(break_flag),
    .break_irq(break_irq), .irq(irq));
  abc_cpu_model u_cpu (.mclk(mclk), .cpu_ready(cpu_ready), .cpu_valid(cpu_valid),
    .cpu_kind(cpu_kind), .cpu_space(cpu_space), .cpu_word(cpu_word), .cpu_addr(cpu_addr),
    .cpu_data(cpu_data));
  // Clock
  always #50 mclk = ~mclk;
  // Hang guard
  always @(posedge mclk)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      num_errors++;
      final_report();
    end
  end
  task automatic final_report;
    $display("checks %0d errors %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : final_report
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("unexpected %s: expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic wait_rdy(output logic [31:0] rd);
    @(negedge mclk);
    while (hreadyout !== 1'b1)
      @(negedge mclk);
    rd = hrdata;
    @(posedge mclk);
  endtask : wait_rdy
  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] rd);
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= w;
    wait_rdy(rd);
    htrans <= 2'h0;
    hwdata <= wd;
    wait_rdy(rd);
  endtask : ahb
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] x;
    ahb(1'b1, a, d, x);
  endtask : wr
  task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] x;
    ahb(1'b0, a, 32'h0, x);
    chk(nm, x, exp);
  endtask : rdc
  // Program match and control, then one cpu access
  task automatic run(input int i);
    logic [57:0] e;
    e = tbl[i];
    wr(ABC_OFS_ADDR, {16'h0, e[47:32]});
    wr(ABC_OFS_CTRL, {28'h0, e[57:54]});
    u_cpu.go(e[53:52], e[51:50], e[49], e[31:16], e[15:0]);
    repeat (2) @(posedge mclk);
  endtask : run
  // Main sequence
  initial
  begin
    // ctrl, kind, space, word, hit, match, access, data; first byte for fetch
    tbl = '{{4'hf, 2'h1, 2'h1, 2'h3, 32'h12341234, 16'ha55a},
      {4'hf, 2'h2, 2'h1, 2'h2, 32'h12351235, 16'ha55a},
      {4'hb, 2'h1, 2'h0, 2'h3, 32'h12351235, 16'h5aa5},
      {4'hd, 2'h2, 2'h1, 2'h1, 32'h12351235, 16'ha55a},
      {4'hb, 2'h2, 2'h1, 2'h2, 32'h12341234, 16'ha55a},
      {4'hd, 2'h2, 2'h2, 2'h3, 32'h12351235, 16'ha55a},
      {4'hf, 2'h1, 2'h2, 2'h3, 32'h12351234, 16'h5aa5},
      {4'hf, 2'h1, 2'h3, 2'h3, 32'h12351235, 16'h5aa5},
      {4'hf, 2'h1, 2'h3, 2'h0, 32'h12341234, 16'ha5a5},
      {4'h1, 2'h0, 2'h0, 2'h3, 32'h12341234, 16'h0000}};
    repeat (4) @(posedge mclk);
    resetn <= 1'b1;
    @(posedge mclk);
    rdc("status", ABC_OFS_STATUS, 32'h3f);
    rdc("address", ABC_OFS_ADDR, 32'hffff);
    wr(ABC_OFS_ADDR, 32'habcd);
    rdc("address", ABC_OFS_ADDR, 32'habcd);
    wr(ABC_OFS_STATUS, 32'h0);
    rdc("status", ABC_OFS_STATUS, 32'h3f);
    rdc("unmapped", 8'h18, 32'h0);
    wr(ABC_OFS_DATA, 32'ha5);
    for (int i = 0; i < 10; i++)
    begin
      run(i);
      rdc("hit", ABC_OFS_STATUS, {24'h0, tbl[i][48], 7'h3f});
      wr(ABC_OFS_STATUS, 32'h0);
    end
    run(0);
    wr(ABC_OFS_STATUS, 32'h40);
    rdc("status", ABC_OFS_STATUS, 32'hff);
    chk("break_irq", {31'h0, break_irq}, 32'h1);
    wr(ABC_OFS_STATUS, 32'h40);
    rdc("status", ABC_OFS_STATUS, 32'h7f);
    chk("break_irq", {31'h0, break_irq}, 32'h0);
    wr(ABC_OFS_EVMASK, 32'h2);
    rdc("evstat", ABC_OFS_EVSTAT, 32'h3);
    chk("irq", {31'h0, irq}, 32'h1);
    wr(ABC_OFS_EVSTAT, 32'h2);
    rdc("evstat", ABC_OFS_EVSTAT, 32'h1);
    chk("irq", {31'h0, irq}, 32'h0);
    // Disabled unit ignores a matching cycle
    wr(ABC_OFS_EVSTAT, 32'h1);
    wr(ABC_OFS_CTRL, 32'he);
    u_cpu.go(2'h1, 2'h1, 1'b1, 16'h1234, 16'ha55a);
    repeat (2) @(posedge mclk);
    rdc("disabled", ABC_OFS_STATUS, 32'h7f);
    rdc("evstat", ABC_OFS_EVSTAT, 32'h0);
    // Unmasked hit event raises irq
    wr(ABC_OFS_EVMASK, 32'h1);
    run(0);
    chk("break_flag", {31'h0, break_flag}, 32'h1);
    chk("break_irq", {31'h0, break_irq}, 32'h1);
    chk("irq", {31'h0, irq}, 32'h1);
    // Reset in mid-run restores address, status and both interrupts
    resetn <= 1'b0;
    repeat (2) @(posedge mclk);
    resetn <= 1'b1;
    @(posedge mclk);
    chk("break_irq", {31'h0, break_irq}, 32'h0);
    chk("irq", {31'h0, irq}, 32'h0);
    rdc("address", ABC_OFS_ADDR, 32'hffff);
    rdc("status", ABC_OFS_STATUS, 32'h3f);
    final_report();
  end
endmodule : testbench
bind abc_top abc_checker u_chk (.mclk(mclk), .resetn(resetn), .hsel(hsel), .htrans(htrans),
  .hwrite(hwrite), .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
  .cpu_valid(cpu_valid), .cpu_word(cpu_word), .cpu_space(cpu_space),
  .cpu_ready(cpu_ready), .break_flag(break_flag), .break_irq(break_irq));
